// ===== inc/sppr_pkg.sv
/*
  Shared constants for the standard printer port register block: register
  offsets, field positions, reset values, port modes and the wait time-out.
  Assumes a 100 MHz ref_clk and an 8-bit host data path.
*/
package sppr_pkg;

  // Host address and data widths
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int SYNC_W = 17;

  // Register offsets
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_STATUS = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  localparam logic [1:0] OFS_NONE = 2'h3;

  // Status field positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_RSVD = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_ERROR = 3;
  localparam int ST_SELECT = 4;
  localparam int ST_PAPER = 5;
  localparam int ST_ACK = 6;
  localparam int ST_READY = 7;

  // Control field positions
  localparam int CT_STROBE = 0;
  localparam int CT_AUTOFEED = 1;
  localparam int CT_INIT = 2;
  localparam int CT_SELIN = 3;
  localparam int CT_IRQ_EN = 4;
  localparam int CT_DIR = 5;

  // Reset values; control bits 7:6 are not stored
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h04;
  localparam logic [1:0] CTRL_RSVD_RD = 2'h3;
  // Pin synchroniser reset: idle pin levels, acknowledge high, initialise low
  localparam logic [16:0] PIN_SYNC_RST = 17'h16014;

  // Peripheral wait time-out: least time, rounded up to whole cycles
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TIMEOUT_PS = 10000000;
  localparam int TIMEOUT_CYC = (TIMEOUT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TO_CNT_W = 11;

  // Operating modes of the standard port
  typedef enum logic [1:0] {
    SPPR_COMPAT = 2'b00,
    SPPR_EXTENDED = 2'b01,
    SPPR_ENHANCED = 2'b10,
    SPPR_MODE_RSVD = 2'b11
  } sppr_mode_t;

endpackage : sppr_pkg

// ===== rtl/sppr_sync.sv
/*
  Two-stage synchroniser for a vector of independent level inputs.
  Assumes each bit is a slow level; no bus coherence across bits is given.
*/
`timescale 1ns/1ps
module sppr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage; reset to idle levels avoids false edges
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage1 <= reset_val;
      sync_out <= reset_val;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : sppr_sync

// ===== rtl/sppr_flag.sv
/*
  Sticky event flag with a set, a clear and a reset value.
  Assumes set and clear are single-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module sppr_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag <= RST_VAL;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_evt) begin
      flag <= 1'b0;
    end
  end

endmodule : sppr_flag

// ===== rtl/sppr_port_regs.sv
/*
  Standard printer port register block: data, status and control registers
  behind an 8-bit host strobe interface, and the printer-side pins.
  Assumes host strobes and mode select are synchronous to ref_clk; printer
  pins are asynchronous and are synchronised here.
  Strobe, auto-feed and select-in float after reset until software first writes the control
  register; the printer-initialise output is held low until then.
*/
// Contract
// - Master reset floats select-in, auto-feed, strobe and interrupt; initialise driven low.
// - Data at 00h, read-only status at 01h, control at 02h; 03h undriven.
// - One data register both ways; direction from control bit 5 and mode.
// - Compatible mode drives written byte, ignores direction, reads return latch.
// - Extended mode, direction 0: drive written bytes, reads return latch.
// - Extended mode, direction 1: reads return pins, writes only update latch.
// - Data register resets to zero.
// - Writes to status register change nothing.
// - Status bit 0 is 1 outside enhanced; there a read-cleared time-out flag.
// - Status bit 1 always reads 1.
// - Status bit 2 latches 0 on acknowledge rise in extended with interrupts.
// - Status bit 3 shows live error input, active low.
// - Status bit 4 shows live printer-selected input.
// - Status bit 5 shows live paper-end input.
// - Status bit 6 tracks acknowledge pin directly.
// - Status bit 7 is the inverse of the busy pin.
// - Control reads give latch, but pin levels when pins are forced externally; here bits 3:0 always read pins, bit 2 reads 0 before the first write.
// - Control bit 0 drives strobe pin inverted.
// - Control bit 1, default 0, drives auto-feed pin inverted.
// - Control bit 2, default 1, drives initialise pin at same level; here the pin is held low until the first control write.
// - Control bit 3, default 0, drives select-in inverted; software clears before enhanced.
// - Control bit 4 gates interrupt; behaviour per mode from acknowledge or time-out.
// - Direction bit write-only in standard modes, reads as 1.
// - Control bits 7 and 6 always read 1.
`timescale 1ns/1ps
module sppr_port_regs (
  input wire logic ref_clk,
  input wire logic srst,
  // Host register interface
  input wire logic [sppr_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [sppr_pkg::DATA_W-1:0] host_wdata,
  output logic [sppr_pkg::DATA_W-1:0] host_rdata,
  output logic host_rdata_oe,
  input wire sppr_pkg::sppr_mode_t port_mode,
  // Enhanced-cycle wait from the cycle engine
  input wire logic epp_wait_stall,
  output logic epp_cycle_abort,
  // Printer data lines
  input wire logic [sppr_pkg::DATA_W-1:0] printer_data_lines_in,
  output logic [sppr_pkg::DATA_W-1:0] printer_data_lines_out,
  output logic printer_data_lines_oe,
  // Printer handshake outputs, open-collector style with read-back
  input wire logic data_strobe_in_n,
  output logic data_strobe_out_n,
  output logic data_strobe_oe,
  input wire logic auto_feed_in_n,
  output logic auto_feed_out_n,
  output logic auto_feed_oe,
  input wire logic printer_init_in_n,
  output logic printer_init_out_n,
  output logic printer_init_oe,
  input wire logic select_in_in_n,
  output logic select_in_out_n,
  output logic select_in_oe,
  // Printer status inputs
  input wire logic ack_in_n,
  input wire logic busy_in,
  input wire logic error_in_n,
  input wire logic printer_selected_in,
  input wire logic paper_end_in,
  // Port interrupt
  output logic port_interrupt,
  output logic port_interrupt_oe
);

  import sppr_pkg::*;

  logic wr_n_d;
  logic rd_n_d;
  logic wr_take;
  logic rd_take;
  logic [DATA_W-1:0] data_latch;
  logic [5:0] ctrl_latch;
  logic drive_en;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_sync;
  logic ack_n_s;
  logic busy_s;
  logic error_n_s;
  logic selected_s;
  logic paper_end_s;
  logic [DATA_W-1:0] data_lines_s;
  logic strobe_n_s;
  logic auto_feed_n_s;
  logic init_n_s;
  logic select_in_n_s;
  logic ack_n_d;
  logic ack_rise;
  logic status_rd;
  logic enhanced;
  logic extended;
  logic enhanced_d;
  logic enhanced_entry;
  logic [TO_CNT_W-1:0] to_cnt;
  logic to_evt;
  logic timeout_flag;
  logic ack_irq_flag;
  logic ack_irq_set;
  logic dir_in;
  logic [DATA_W-1:0] status_val;
  logic [DATA_W-1:0] control_val;
  logic [DATA_W-1:0] next_rdata;

  // Printer pins cross into ref_clk before any logic sees them
  assign pins_raw = {select_in_in_n, printer_init_in_n, auto_feed_in_n, data_strobe_in_n,
                     printer_data_lines_in,
                     ack_in_n, busy_in, error_in_n, printer_selected_in, paper_end_in};

  sppr_sync #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(pins_raw),
    .reset_val(PIN_SYNC_RST), // Idle levels, so no acknowledge edge follows reset
    .sync_out(pins_sync)
  );

  assign paper_end_s = pins_sync[0];
  assign selected_s = pins_sync[1];
  assign error_n_s = pins_sync[2];
  assign busy_s = pins_sync[3];
  assign ack_n_s = pins_sync[4];
  assign data_lines_s = pins_sync[12:5];
  assign strobe_n_s = pins_sync[13];
  assign auto_feed_n_s = pins_sync[14];
  assign init_n_s = pins_sync[15];
  assign select_in_n_s = pins_sync[16];

  // Strobe history; an access is taken once, on the first low cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_n_d <= 1'b1;
      rd_n_d <= 1'b1;
      ack_n_d <= 1'b1;
      enhanced_d <= 1'b0;
    end else begin
      wr_n_d <= host_wr_n;
      rd_n_d <= host_rd_n;
      ack_n_d <= ack_n_s;
      enhanced_d <= enhanced;
    end
  end

  assign wr_take = !host_wr_n && wr_n_d;
  assign rd_take = !host_rd_n && rd_n_d;
  assign status_rd = rd_take && (host_addr == OFS_STATUS);
  assign ack_rise = ack_n_s && !ack_n_d;
  assign enhanced = (port_mode == SPPR_ENHANCED);
  assign extended = (port_mode == SPPR_EXTENDED) || enhanced;
  assign enhanced_entry = enhanced && !enhanced_d;
  // Direction only matters in extended and enhanced modes
  assign dir_in = extended && ctrl_latch[CT_DIR];

  // Data latch; a write lands here in every mode and direction
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_latch <= DATA_RST;
    end else if (wr_take && host_addr == OFS_DATA) begin
      data_latch <= host_wdata;
    end
  end

  // Control latch; status and unused offsets take no write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_latch <= CTRL_RST;
      drive_en <= 1'b0;
    end else if (wr_take && host_addr == OFS_CONTROL) begin
      ctrl_latch <= host_wdata[5:0];
      drive_en <= 1'b1;
    end
  end

  // Peripheral wait counter; a stall reaching the limit aborts the cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      to_cnt <= '0;
      to_evt <= 1'b0;
    end else if (enhanced && epp_wait_stall) begin
      to_evt <= (to_cnt == TO_CNT_W'(TIMEOUT_CYC - 1));
      if (to_cnt != TO_CNT_W'(TIMEOUT_CYC)) begin
        to_cnt <= to_cnt + 1'b1;
      end
    end else begin
      to_cnt <= '0;
      to_evt <= 1'b0;
    end
  end

  // Time-out flag: reset default 1, cleared on entry and on status read
  sppr_flag #(
    .RST_VAL(1'b1)
  ) u_timeout_flag (
    .ref_clk(ref_clk),
    .srst(srst),
    .set_evt(to_evt),
    .clr_evt(enhanced_entry || status_rd),
    .flag(timeout_flag)
  );

  // Acknowledge latch, armed only in extended mode with interrupts on
  assign ack_irq_set = ack_rise && (port_mode == SPPR_EXTENDED) && ctrl_latch[CT_IRQ_EN];

  sppr_flag #(
    .RST_VAL(1'b0)
  ) u_ack_flag (
    .ref_clk(ref_clk),
    .srst(srst),
    .set_evt(ack_irq_set),
    .clr_evt(status_rd || !ctrl_latch[CT_IRQ_EN]),
    .flag(ack_irq_flag)
  );

  // Status byte assembled from synchronised pins and flags
  always_comb begin
    status_val = '0;
    status_val[ST_TIMEOUT] = enhanced ? timeout_flag : 1'b1;
    status_val[ST_RSVD] = 1'b1;
    status_val[ST_IRQ] = !ack_irq_flag;
    status_val[ST_ERROR] = error_n_s;
    status_val[ST_SELECT] = selected_s;
    status_val[ST_PAPER] = paper_end_s;
    status_val[ST_ACK] = ack_n_s;
    status_val[ST_READY] = !busy_s;
  end

  // Control bits 3:0 read back from the pins, so an external override shows
  always_comb begin
    control_val = '0;
    control_val[CT_STROBE] = !strobe_n_s;
    control_val[CT_AUTOFEED] = !auto_feed_n_s;
    control_val[CT_INIT] = init_n_s;
    control_val[CT_SELIN] = !select_in_n_s;
    control_val[CT_IRQ_EN] = ctrl_latch[CT_IRQ_EN];
    control_val[CT_DIR] = enhanced ? ctrl_latch[CT_DIR] : 1'b1;
    control_val[7:6] = CTRL_RSVD_RD;
  end

  // Read multiplexer; the latch is returned unless the port is turned round
  always_comb begin
    case (host_addr)
      OFS_DATA: begin
        next_rdata = dir_in ? data_lines_s : data_latch;
      end
      OFS_STATUS: begin
        next_rdata = status_val;
      end
      OFS_CONTROL: begin
        next_rdata = control_val;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data and enable registered every cycle; the enable follows the read strobe one cycle late; 03h is never driven
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      host_rdata <= '0;
      host_rdata_oe <= 1'b0;
    end else begin
      host_rdata <= next_rdata;
      host_rdata_oe <= !host_rd_n && (host_addr != OFS_NONE);
    end
  end

  // Data lines: driven unless extended or enhanced mode points them inward
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      printer_data_lines_out <= DATA_RST;
      printer_data_lines_oe <= 1'b0;
    end else begin
      printer_data_lines_out <= data_latch;
      printer_data_lines_oe <= !dir_in;
    end
  end

  // Strobe, auto-feed and select-in float until software first writes control; initialise is always driven
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_strobe_out_n <= 1'b1;
      data_strobe_oe <= 1'b0;
      auto_feed_out_n <= 1'b1;
      auto_feed_oe <= 1'b0;
      select_in_out_n <= 1'b1;
      select_in_oe <= 1'b0;
      printer_init_out_n <= 1'b0;
      printer_init_oe <= 1'b1;
    end else begin
      data_strobe_out_n <= !ctrl_latch[CT_STROBE];
      data_strobe_oe <= drive_en;
      auto_feed_out_n <= !ctrl_latch[CT_AUTOFEED];
      auto_feed_oe <= drive_en;
      // Software must clear select-in before going enhanced; not checked here
      select_in_out_n <= !ctrl_latch[CT_SELIN];
      select_in_oe <= drive_en;
      printer_init_out_n <= drive_en ? ctrl_latch[CT_INIT] : 1'b0;
      printer_init_oe <= 1'b1;
    end
  end

  // Interrupt line floats unless enabled; behaviour per mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port_interrupt <= 1'b0;
      port_interrupt_oe <= 1'b0;
    end else if (!ctrl_latch[CT_IRQ_EN]) begin
      port_interrupt <= 1'b0;
      port_interrupt_oe <= 1'b0;
    end else begin
      port_interrupt_oe <= 1'b1;
      case (port_mode)
        SPPR_EXTENDED: begin
          port_interrupt <= ack_irq_flag;
        end
        SPPR_ENHANCED: begin
          port_interrupt <= ack_n_s || to_evt;
        end
        default: begin
          port_interrupt <= ack_n_s;
        end
      endcase
    end
  end

  // Abort pulse for the cycle engine when the wait runs out
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      epp_cycle_abort <= 1'b0;
    end else begin
      epp_cycle_abort <= to_evt;
    end
  end

endmodule : sppr_port_regs

// ===== dv/sppr_printer_model.sv
/*
  Printer on the far side of the port: status levels set by the bench,
  an acknowledge pulse after each strobe, data driven once the port lets go.
  Assumes ref_clk as its timing base; a real printer is asynchronous.
*/
`timescale 1ns/1ps
module sppr_printer_model (
  input wire logic ref_clk,
  input wire logic data_strobe_out_n,
  input wire logic [7:0] printer_data_lines_out,
  input wire logic printer_data_lines_oe,
  input wire logic [3:0] st_lvl,
  output logic [7:0] printer_data_lines_in,
  output logic ack_in_n,
  output logic busy_in,
  output logic error_in_n,
  output logic printer_selected_in,
  output logic paper_end_in
);
  logic [2:0] ack_cnt = 3'h0;
  logic stb_q = 1'b1;
  // Port wins while enabled, otherwise the printer puts its own byte out
  assign printer_data_lines_in = printer_data_lines_oe ? printer_data_lines_out : 8'h96;
  assign {busy_in, paper_end_in, printer_selected_in, error_in_n} = st_lvl;
  assign ack_in_n = ack_cnt == 3'h0;
  // Acknowledge low for seven cycles after a strobe falls; edge only, so a held strobe is one character
  always_ff @(posedge ref_clk) begin
    stb_q <= data_strobe_out_n;
    if (ack_cnt != 3'h0) ack_cnt <= ack_cnt + 3'h1; // Wraps back to idle
    else if (stb_q && !data_strobe_out_n) ack_cnt <= 3'h1;
  end
endmodule : sppr_printer_model

// ===== dv/sppr_port_regs_chk.sv
/*
  Port-level assertions for the printer port register block.
  Assumes one clock, ref_clk, and the synchronous reset srst.
*/
`timescale 1ns/1ps
module sppr_port_regs_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [sppr_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [sppr_pkg::DATA_W-1:0] host_wdata,
  input wire logic [sppr_pkg::DATA_W-1:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire sppr_pkg::sppr_mode_t port_mode,
  input wire logic busy_in,
  input wire logic epp_wait_stall,
  input wire logic epp_cycle_abort,
  input wire logic [sppr_pkg::DATA_W-1:0] printer_data_lines_out,
  input wire logic printer_data_lines_oe,
  input wire logic data_strobe_out_n,
  input wire logic data_strobe_oe,
  input wire logic auto_feed_out_n,
  input wire logic auto_feed_oe,
  input wire logic printer_init_out_n,
  input wire logic printer_init_oe,
  input wire logic select_in_out_n,
  input wire logic select_in_oe,
  input wire logic port_interrupt_oe
);
  import sppr_pkg::*;
  logic [10:0] stall_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Consecutive enhanced stall cycles; saturates so a long stall never wraps
  always_ff @(posedge ref_clk) begin
    if (srst || !epp_wait_stall || port_mode != SPPR_ENHANCED) stall_cnt <= 11'h000;
    else if (stall_cnt != 11'h7ff) stall_cnt <= stall_cnt + 11'h001;
  end
  property p_init_rst; disable iff (1'b0) srst |=> !printer_init_out_n && printer_init_oe; endproperty
  a_init_rst: assert property (p_init_rst) else $error("init not low in reset");
  property p_float_rst;
    disable iff (1'b0) srst |=> !(data_strobe_oe || auto_feed_oe || select_in_oe || port_interrupt_oe);
  endproperty
  a_float_rst: assert property (p_float_rst) else $error("outputs driven in reset");
  property p_rd_oe; !host_rd_n |=> host_rdata_oe == ($past(host_addr) != OFS_NONE); endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read enable wrong");
  property p_status;
    host_rdata_oe && $past(host_addr) == OFS_STATUS && $past(busy_in, 2) == $past(busy_in, 3) &&
      $past(busy_in, 3) == $past(busy_in, 4) |-> host_rdata[ST_RSVD] && host_rdata[ST_READY] != $past(busy_in, 3);
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");
  property p_ctl_rd;
    host_rdata_oe && $past(host_addr) == OFS_CONTROL |->
      host_rdata[7:6] == CTRL_RSVD_RD && (host_rdata[CT_DIR] || $past(port_mode) == SPPR_ENHANCED);
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control fixed bits wrong");
  property p_pd_oe; port_mode == SPPR_COMPAT && !$past(srst) |=> printer_data_lines_oe; endproperty
  a_pd_oe: assert property (p_pd_oe) else $error("data lines not driven");
  property p_pd_wr; $fell(host_wr_n) && host_addr == OFS_DATA |-> ##2 printer_data_lines_out == $past(host_wdata, 2);
  endproperty
  a_pd_wr: assert property (p_pd_wr) else $error("data latch wrong");
  property p_ctl_wr;
    $fell(host_wr_n) && host_addr == OFS_CONTROL |-> ##2 data_strobe_oe &&
      data_strobe_out_n != $past(host_wdata[CT_STROBE], 2) && auto_feed_out_n != $past(host_wdata[CT_AUTOFEED], 2) &&
      select_in_out_n != $past(host_wdata[CT_SELIN], 2) && printer_init_out_n == $past(host_wdata[CT_INIT], 2);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("handshake outputs wrong");
  property p_irq_oe;
    $fell(host_wr_n) && host_addr == OFS_CONTROL |-> ##2 port_interrupt_oe == $past(host_wdata[CT_IRQ_EN], 2);
  endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("interrupt float wrong");
  property p_abort; stall_cnt == TIMEOUT_CYC |-> ##[0:2] epp_cycle_abort; endproperty
  a_abort: assert property (p_abort) else $error("no abort on time-out");
endmodule : sppr_port_regs_chk

bind sppr_port_regs sppr_port_regs_chk u_sppr_port_regs_chk (.*);

// ===== dv/test_spp_printer_port_registers.sv
/*
  Self-checking bench for the printer port register block and a printer model.
  Assumes the checker is bound in and pull-ups sit on the handshake lines.
*/
`timescale 1ns/1ps
module test_spp_printer_port_registers;
  import sppr_pkg::*;
  typedef struct packed {
    sppr_mode_t mode;
    logic [1:0] wa;
    logic [7:0] wd;
    logic frc;
    logic [3:0] pins;
    logic [1:0] ra;
    logic [7:0] exp;
  } sppr_row_t;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic host_rd_n = 1'b1, host_wr_n = 1'b1, epp_wait_stall = 1'b0, frc = 1'b0, ro;
  logic [1:0] host_addr = 2'h0;
  logic [7:0] host_wdata = 8'h00, host_rdata, printer_data_lines_in, printer_data_lines_out, d;
  logic [3:0] st_lvl = 4'h3;
  sppr_mode_t port_mode = SPPR_COMPAT;
  logic host_rdata_oe, epp_cycle_abort, printer_data_lines_oe, data_strobe_out_n, data_strobe_oe, auto_feed_out_n;
  logic auto_feed_oe, printer_init_out_n, printer_init_oe, select_in_out_n, select_in_oe, port_interrupt;
  logic port_interrupt_oe, ack_in_n, busy_in, error_in_n, printer_selected_in, paper_end_in;
  logic data_strobe_in_n, auto_feed_in_n, printer_init_in_n, select_in_in_n;
  int fail_count = 0, n_checks = 0, ab;
  // Select-in is cleared before the enhanced rows
  sppr_row_t rows [11] = '{
    '{SPPR_COMPAT,2'h0,8'ha5,1'b0,4'h3,2'h0,8'ha5}, '{SPPR_COMPAT,2'h1,8'h00,1'b0,4'h3,2'h1,8'hdf},
    '{SPPR_COMPAT,2'h2,8'h2b,1'b0,4'h3,2'h2,8'heb}, '{SPPR_COMPAT,2'h0,8'h3c,1'b0,4'h3,2'h0,8'h3c},
    '{SPPR_COMPAT,2'h1,8'h00,1'b0,4'hc,2'h1,8'h67}, '{SPPR_EXTENDED,2'h0,8'h5a,1'b0,4'h3,2'h0,8'h96},
    '{SPPR_EXTENDED,2'h2,8'h04,1'b0,4'h3,2'h2,8'he4}, '{SPPR_EXTENDED,2'h0,8'h77,1'b0,4'h3,2'h0,8'h77},
    '{SPPR_ENHANCED,2'h2,8'h04,1'b0,4'h3,2'h2,8'hc4}, '{SPPR_ENHANCED,2'h3,8'hff,1'b0,4'h3,2'h1,8'hde},
    '{SPPR_COMPAT,2'h2,8'h00,1'b1,4'h3,2'h2,8'he1}};
  // Released lines float high; frc pulls the strobe low from outside
  assign data_strobe_in_n = !frc && (!data_strobe_oe || data_strobe_out_n);
  assign auto_feed_in_n = !auto_feed_oe || auto_feed_out_n;
  assign printer_init_in_n = !printer_init_oe || printer_init_out_n;
  assign select_in_in_n = !select_in_oe || select_in_out_n;
  sppr_port_regs u_sppr_port_regs (.*);
  sppr_printer_model u_sppr_printer_model (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Write then idle long enough for synchronised read-back to settle
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk) #1;
    host_addr = a;
    host_wdata = v;
    host_wr_n = 1'b0;
    @(posedge ref_clk) #1;
    host_wr_n = 1'b1;
    repeat (5) @(posedge ref_clk) #1;
  endtask : wr
  task automatic rd(input logic [1:0] a);
    @(posedge ref_clk) #1;
    host_addr = a;
    host_rd_n = 1'b0;
    @(posedge ref_clk) #1;
    d = host_rdata;
    ro = host_rdata_oe;
    host_rd_n = 1'b1;
  endtask : rd
  task automatic stall(input int n);
    ab = 0;
    repeat (n) begin
      @(posedge ref_clk) #1;
      if (epp_cycle_abort === 1'b1) ab++;
    end
  endtask : stall
  task automatic rst;
    srst = 1'b1;
    repeat (8) @(posedge ref_clk) #1;
    chk("reset pins", {2'h0, printer_init_out_n, printer_init_oe, data_strobe_oe, auto_feed_oe, select_in_oe,
      port_interrupt_oe}, 8'h10);
    srst = 1'b0;
    $display("reset test done");
  endtask : rst
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Table rows, then a second reset mid-run and the event cases
  initial begin
    rst();
    for (int i = 0; i < 11; i++) begin
      port_mode = rows[i].mode;
      st_lvl = rows[i].pins;
      frc = rows[i].frc;
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      chk("row", d, rows[i].exp);
      $display("row %0d done", i);
    end
    frc = 1'b0;
    port_mode = SPPR_COMPAT;
    rst();
    rd(2'h0);
    chk("data after reset", d, 8'h00);
    rd(2'h2);
    chk("control after reset", d, 8'he0);
    rd(2'h3);
    chk("unmapped enable", {7'h0, ro}, 8'h00);
    port_mode = SPPR_EXTENDED;
    wr(2'h2, 8'h14);
    wr(2'h2, 8'h15);
    rd(2'h1);
    chk("status during ack", d, 8'h9f);
    wr(2'h2, 8'h14);
    chk("irq pending", {6'h0, port_interrupt, port_interrupt_oe}, 8'h03);
    rd(2'h1);
    chk("status irq latched", d, 8'hdb);
    rd(2'h1);
    chk("status irq cleared", d, 8'hdf);
    chk("irq cleared", {6'h0, port_interrupt, port_interrupt_oe}, 8'h01);
    $display("ack test done");
    port_mode = SPPR_ENHANCED;
    epp_wait_stall = 1'b1;
    stall(990);
    chk("early abort", ab[7:0], 8'h00);
    stall(20);
    chk("abort", ab[7:0], 8'h01);
    epp_wait_stall = 1'b0;
    rd(2'h1);
    chk("status timeout", d, 8'hdf);
    rd(2'h1);
    chk("status timeout cleared", d, 8'hde);
    $display("timeout test done");
    // Compatible mode: interrupt line follows the synchronised acknowledge level
    port_mode = SPPR_COMPAT;
    wr(2'h2, 8'h15);
    chk("irq follows ack low", {6'h0, port_interrupt, port_interrupt_oe}, 8'h01);
    rd(2'h1);
    chk("status ack compat", d, 8'h9f);
    wr(2'h2, 8'h14);
    chk("irq follows ack high", {6'h0, port_interrupt, port_interrupt_oe}, 8'h03);
    $display("compat irq test done");
    summarize();
  end
  // Cut a hang short well past the expected run of about 12 us
  initial begin
    #50000;
    fail_count++;
    summarize();
  end
endmodule : test_spp_printer_port_registers
